// file: ucf_map.svh
// Register offsets, field positions, reset values and counts of the clock and frame generator
`ifndef UCF_MAP_SVH
`define UCF_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define UCF_OFF_DATA 8'h00
`define UCF_OFF_STATUS 8'h04
`define UCF_OFF_CTRL_B 8'h08
`define UCF_OFF_CTRL_C 8'h0c
`define UCF_OFF_BAUD 8'h10
`define UCF_OFF_PIN 8'h14

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define UCF_ST_RXFULL 0
`define UCF_ST_TXEMPTY 1
`define UCF_ST_TXDONE 2
`define UCF_ST_PERR 3
`define UCF_ST_FERR 4
`define UCF_ST_BUSY 5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define UCF_RST_CTRL_B 5'h00
`define UCF_RST_CTRL_C 10'h060
`define UCF_RST_BAUD 16'h0000
`define UCF_RST_PIN 1'h0

// ----------------------------------------
// Codes and counts
// ----------------------------------------
`define UCF_SPB_NORMAL 5'h10
`define UCF_SPB_DOUBLE 5'h08
`define UCF_COMMUNICATION_MODE_FIELD_SPI 2'h3
`define UCF_SPI_BITS 4'h8
`define UCF_CHSIZE_MAX 3'h4
`define UCF_BITS_MIN 4'h5
`define UCF_BITS_MAX 4'h9
`define UCF_RESP_OKAY 2'h0
`define UCF_RESP_SLVERR 2'h2

`endif

// file: ucf_pkg.sv
// Types and shared helpers of the clock and frame generator
`default_nettype none
package ucf_pkg;

	// ----------------------------------------
	// States
	// ----------------------------------------
	typedef enum logic [1:0] {
		UCF_TX_IDLE = 2'b01,
		UCF_TX_SHIFT = 2'b10
	} ucf_tx_state_type;

	typedef enum logic [2:0] {
		UCF_RX_IDLE = 3'b001,
		UCF_RX_START = 3'b010,
		UCF_RX_SHIFT = 3'b100
	} ucf_rx_state_type;

	// ----------------------------------------
	// Register layouts
	// ----------------------------------------
	typedef struct packed {
		logic order;
		logic phase;
		logic [2:0] chsize;
		logic stop2;
		logic [1:0] parity_mode_field;
		logic [1:0] communication_mode_field;
	} ucf_frame_cfg_type;

	typedef struct packed {
		logic xck_master;
		logic open_drain;
		logic double_speed;
		logic tx_en;
		logic rx_en;
	} ucf_ctrl_type;

	// Parity over the first n bits; odd selects odd parity
	function automatic logic ucf_parity(input logic [8:0] d, input logic [3:0] n, input logic odd);
		logic p;
		p = odd;
		for (int i = 0; i < 9; i++) begin
			if (i < int'(n)) begin
				p = p ^ d[i];
			end
		end
		return p;
	endfunction

	function automatic logic [31:0] ucf_merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

endpackage

`default_nettype wire

// file: ucf_sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none

module ucf_sync2 #(
	parameter int W = 2
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q_r
);

	logic [W-1:0] meta_r;

	// Pins idle high, so both stages reset high
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_r <= '1;
			q_r <= '1;
		end else begin
			meta_r <= d;
			q_r <= meta_r;
		end
	end

endmodule

`default_nettype wire

// file: ucf_baud_gen.sv
// Fractional bit rate generator: sample ticks when asynchronous, half-period ticks when synchronous
`timescale 1ns/1ns
`default_nettype none

module ucf_baud_gen #(
	parameter int DIV_W = 16,
	parameter int FRAC_W = 6
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [DIV_W-1:0] divisor,
	input wire logic sync_mode,
	output logic tick_r
);

	localparam int IW = DIV_W - FRAC_W;
	localparam logic [DIV_W:0] STEP = (DIV_W+1)'(2**FRAC_W);

	logic [DIV_W:0] acc_r;
	logic [DIV_W:0] acc_sum;
	logic [IW-1:0] hcnt_r;
	logic [IW:0] hnext;

	assign acc_sum = acc_r + STEP;
	assign hnext = {1'b0, hcnt_r} + {{IW{1'b0}}, 1'b1};

	// A divisor below one integer step cannot tick faster than the clock
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_r <= '0;
			hcnt_r <= '0;
			tick_r <= 1'b0;
		end else if (sync_mode) begin
			acc_r <= '0;
			if (hnext >= {1'b0, divisor[DIV_W-1:FRAC_W]}) begin
				hcnt_r <= '0;
				tick_r <= 1'b1;
			end else begin
				hcnt_r <= hnext[IW-1:0];
				tick_r <= 1'b0;
			end
		end else begin
			hcnt_r <= '0;
			if (acc_sum >= {1'b0, divisor}) begin
				acc_r <= acc_sum - {1'b0, divisor};
				tick_r <= 1'b1;
			end else begin
				acc_r <= acc_sum;
				tick_r <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

// file: usart_clock_frame_gen.sv
// Clock generation, frame composition and register slave of the serial unit
// ----------------------------------------
// ----------------------------------------
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "ucf_map.svh"

module usart_clock_frame_gen (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rxd_in,
	output logic txd_out,
	output logic txd_oe,
	input wire logic sync_clock_pin_in,
	output logic sync_clock_pin_out,
	output logic sync_clock_pin_oe
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	ucf_pkg::ucf_ctrl_type ctrl_r;
	ucf_pkg::ucf_frame_cfg_type fcfg_r;
	logic [15:0] baud_r;
	logic invert_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic wr_go, wr_ok, rd_ok, rd_data;
	logic [31:0] rd_val, stat;
	logic bg_tick, sync_m, spi, pre, master_clk;
	logic [4:0] spb, half;
	logic [3:0] nb;
	logic rxd_s, xck_s, xk_lvl, xk_prev_r, xk_rise, xk_fall, xk_chg, xk_smp;
	logic xck_int_r, xck_int_nxt;
	ucf_pkg::ucf_tx_state_type tx_state_r, tx_state_nxt;
	logic [12:0] tx_frame_r, tx_frame_nxt;
	logic [3:0] tx_left_r, tx_left_nxt, tx_scnt_r, tx_scnt_nxt;
	logic tx_pres_r, tx_pres_nxt, txd_nxt, tx_load, tx_fin;
	logic [8:0] tx_buf_r;
	logic tx_buf_full_r, tx_done_r;
	ucf_pkg::ucf_rx_state_type rx_state_r;
	logic [4:0] rx_cnt_r, rx_sn;
	logic [1:0] rx_hi_r;
	logic [3:0] rx_idx_r, rx_n, rx_pos;
	logic [8:0] rx_sh_r, rx_word, rx_data_r;
	logic rx_par_r, rx_full_r, rx_perr_r, rx_ferr_r;
	logic rx_start, rx_go, rx_abort, rx_bit, rx_fin, rx_val;

	function automatic logic [3:0] nbits(input logic [2:0] cs);
		return (cs > `UCF_CHSIZE_MAX) ? `UCF_BITS_MAX : ({1'b0, cs} + `UCF_BITS_MIN);
	endfunction

	// Frame bits in line order; unused top positions stay high as stop level
	function automatic logic [12:0] tx_build(input logic [8:0] d,
		input ucf_pkg::ucf_frame_cfg_type c);
		logic [12:0] f;
		logic [3:0] n;
		f = 13'h1fff;
		n = nbits(c.chsize);
		if (c.communication_mode_field == `UCF_COMMUNICATION_MODE_FIELD_SPI) begin
			for (int i = 0; i < 8; i++) begin
				f[i] = c.order ? d[i] : d[7-i];
			end
		end else begin
			f[0] = 1'b0;
			for (int i = 0; i < 9; i++) begin
				if (i < int'(n)) begin
					f[1+i] = d[i];
				end
			end
			if (c.parity_mode_field[1]) begin
				f[4'd1 + n] = ucf_pkg::ucf_parity(d, n, c.parity_mode_field[0]);
			end
		end
		return f;
	endfunction

	// ----------------------------------------
	// Mode decode and bit rate generator
	// ----------------------------------------
	assign sync_m = fcfg_r.communication_mode_field[0];
	assign spi = (fcfg_r.communication_mode_field == `UCF_COMMUNICATION_MODE_FIELD_SPI);
	assign master_clk = sync_m && (spi || ctrl_r.xck_master);
	assign pre = spi && !fcfg_r.phase;
	assign spb = ctrl_r.double_speed ? `UCF_SPB_DOUBLE : `UCF_SPB_NORMAL;
	assign half = {1'b0, spb[4:1]};
	assign nb = nbits(fcfg_r.chsize);

	ucf_baud_gen #(
		.DIV_W(16),
		.FRAC_W(6)
	) u_baud (
		.aclk(aclk),
		.aresetn(aresetn),
		.divisor(baud_r),
		.sync_mode(sync_m),
		.tick_r(bg_tick)
	);

	ucf_sync2 #(
		.W(2)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({sync_clock_pin_in, rxd_in}),
		.q_r({xck_s, rxd_s})
	);

	// ----------------------------------------
	// Transfer clock
	// ----------------------------------------
	// Inversion sits at the pin, so internal edges keep fixed roles
	assign xk_lvl = master_clk ? xck_int_r : (xck_s ^ invert_r);
	assign xk_rise = sync_m && xk_lvl && !xk_prev_r;
	assign xk_fall = sync_m && !xk_lvl && xk_prev_r;
	assign xk_chg = pre ? xk_fall : xk_rise;
	assign xk_smp = pre ? xk_rise : xk_fall;

	always_comb begin
		xck_int_nxt = xck_int_r;
		if (master_clk && bg_tick && (tx_state_r == ucf_pkg::UCF_TX_SHIFT || xck_int_r)) begin
			xck_int_nxt = !xck_int_r;
		end
		if (!master_clk) begin
			xck_int_nxt = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xck_int_r <= 1'b0;
			xk_prev_r <= 1'b0;
			sync_clock_pin_out <= 1'b0;
			sync_clock_pin_oe <= 1'b0;
		end else begin
			xck_int_r <= xck_int_nxt;
			xk_prev_r <= xk_lvl;
			sync_clock_pin_out <= xck_int_nxt ^ invert_r;
			sync_clock_pin_oe <= master_clk;
		end
	end

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	always_comb begin
		tx_state_nxt = tx_state_r;
		tx_frame_nxt = tx_frame_r;
		tx_left_nxt = tx_left_r;
		tx_scnt_nxt = tx_scnt_r;
		tx_pres_nxt = tx_pres_r;
		txd_nxt = txd_out;
		tx_load = 1'b0;
		tx_fin = 1'b0;
		case (tx_state_r)
			ucf_pkg::UCF_TX_IDLE: begin
				txd_nxt = 1'b1;
				tx_load = tx_buf_full_r && ctrl_r.tx_en;
			end
			ucf_pkg::UCF_TX_SHIFT: begin
				if (!sync_m) begin
					if (bg_tick) begin
						tx_scnt_nxt = tx_scnt_r + 4'h1;
						if ({1'b0, tx_scnt_r} == spb - 5'h01) begin
							tx_scnt_nxt = 4'h0;
							if (tx_left_r == 4'h1) begin
								tx_fin = 1'b1;
							end else begin
								tx_frame_nxt = tx_frame_r >> 1;
								txd_nxt = tx_frame_r[1];
								tx_left_nxt = tx_left_r - 4'h1;
							end
						end
					end
				end else if (xk_smp) begin
					tx_left_nxt = tx_left_r - 4'h1;
					if (tx_left_r == 4'h1 && !pre) begin
						tx_fin = 1'b1;
					end
				end else if (xk_chg) begin
					if (tx_left_r == 4'h0 && pre) begin
						tx_fin = 1'b1;
					end else if (tx_pres_r) begin
						tx_frame_nxt = tx_frame_r >> 1;
						txd_nxt = tx_frame_r[1];
					end else begin
						tx_pres_nxt = 1'b1;
						txd_nxt = tx_frame_r[0];
					end
				end
			end
			default: begin
				tx_state_nxt = ucf_pkg::UCF_TX_IDLE;
			end
		endcase
		if (tx_fin) begin
			txd_nxt = 1'b1;
			tx_state_nxt = ucf_pkg::UCF_TX_IDLE;
			tx_load = tx_buf_full_r && ctrl_r.tx_en;
		end
		if (tx_load) begin
			tx_frame_nxt = tx_build(tx_buf_r, fcfg_r);
			tx_left_nxt = spi ? `UCF_SPI_BITS : (4'h2 + nb + {3'h0, fcfg_r.parity_mode_field[1]}
				+ {3'h0, fcfg_r.stop2});
			tx_scnt_nxt = 4'h0;
			tx_state_nxt = ucf_pkg::UCF_TX_SHIFT;
			tx_pres_nxt = !sync_m || pre;
			if (!sync_m || pre) begin
				txd_nxt = tx_frame_nxt[0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_state_r <= ucf_pkg::UCF_TX_IDLE;
			tx_frame_r <= 13'h1fff;
			tx_left_r <= 4'h0;
			tx_scnt_r <= 4'h0;
			tx_pres_r <= 1'b0;
			txd_out <= 1'b1;
			txd_oe <= 1'b0;
		end else begin
			tx_state_r <= tx_state_nxt;
			tx_frame_r <= tx_frame_nxt;
			tx_left_r <= tx_left_nxt;
			tx_scnt_r <= tx_scnt_nxt;
			tx_pres_r <= tx_pres_nxt;
			txd_out <= txd_nxt;
			// Wired-AND only pulls low; a high is left to the line
			txd_oe <= (ctrl_r.tx_en || tx_state_nxt == ucf_pkg::UCF_TX_SHIFT)
				&& (!ctrl_r.open_drain || !txd_nxt);
		end
	end

	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	assign rx_sn = (rx_cnt_r == spb) ? 5'h01 : (rx_cnt_r + 5'h01);
	assign rx_n = spi ? `UCF_SPI_BITS : nb;
	assign rx_pos = (spi && !fcfg_r.order) ? (4'h7 - rx_idx_r) : rx_idx_r;

	always_comb begin
		rx_start = 1'b0;
		rx_go = 1'b0;
		rx_abort = 1'b0;
		rx_bit = 1'b0;
		rx_fin = 1'b0;
		rx_val = rxd_s;
		rx_word = rx_sh_r;
		if (!sync_m) begin
			if (bg_tick) begin
				if (rx_state_r == ucf_pkg::UCF_RX_IDLE) begin
					rx_start = !rxd_s;
				end else if (rx_sn == half + 5'h02) begin
					// Majority of the three centre samples
					rx_val = ({1'b0, rx_hi_r} + {2'h0, rxd_s}) >= 3'h2;
					if (rx_state_r == ucf_pkg::UCF_RX_START) begin
						rx_abort = rx_val;
						rx_go = !rx_val;
					end else begin
						rx_bit = 1'b1;
					end
				end
			end
		end else if (xk_smp) begin
			if (rx_state_r == ucf_pkg::UCF_RX_IDLE) begin
				rx_bit = spi;
				rx_start = !spi && !rxd_s;
			end else begin
				rx_bit = 1'b1;
			end
		end
		if (rx_bit) begin
			if (rx_idx_r < rx_n) begin
				rx_word[rx_pos] = rx_val;
				rx_fin = spi && (rx_idx_r == `UCF_SPI_BITS - 4'h1);
			end else if (!(fcfg_r.parity_mode_field[1] && rx_idx_r == rx_n)) begin
				rx_fin = 1'b1; // First stop bit ends the frame; a second is ignored
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !ctrl_r.rx_en) begin
			rx_state_r <= ucf_pkg::UCF_RX_IDLE;
			rx_cnt_r <= 5'h00;
			rx_hi_r <= 2'h0;
			rx_idx_r <= 4'h0;
			rx_sh_r <= 9'h000;
			rx_par_r <= 1'b0;
		end else begin
			if (bg_tick && !sync_m && rx_state_r != ucf_pkg::UCF_RX_IDLE) begin
				rx_cnt_r <= rx_sn;
				if (rx_sn == half || rx_sn == half + 5'h01) begin
					rx_hi_r <= rx_hi_r + {1'b0, rxd_s};
				end else begin
					rx_hi_r <= 2'h0;
				end
			end
			if (rx_start) begin
				rx_state_r <= sync_m ? ucf_pkg::UCF_RX_SHIFT : ucf_pkg::UCF_RX_START;
				rx_cnt_r <= 5'h01;
				rx_hi_r <= 2'h0;
				rx_idx_r <= 4'h0;
				rx_sh_r <= 9'h000;
			end
			if (rx_abort) begin
				rx_state_r <= ucf_pkg::UCF_RX_IDLE;
			end
			if (rx_go) begin
				rx_state_r <= ucf_pkg::UCF_RX_SHIFT;
			end
			if (rx_bit) begin
				rx_state_r <= ucf_pkg::UCF_RX_SHIFT;
				rx_sh_r <= rx_word;
				rx_idx_r <= rx_idx_r + 4'h1;
				if (rx_idx_r == rx_n) begin
					rx_par_r <= rx_val;
				end
			end
			if (rx_fin) begin
				rx_state_r <= ucf_pkg::UCF_RX_IDLE;
				rx_idx_r <= 4'h0;
				rx_sh_r <= 9'h000;
			end
		end
	end

	// Disabling the receiver flushes the held character at once
	always_ff @(posedge aclk) begin
		if (!aresetn || !ctrl_r.rx_en) begin
			rx_data_r <= 9'h000;
			rx_full_r <= 1'b0;
			rx_perr_r <= 1'b0;
			rx_ferr_r <= 1'b0;
		end else if (rx_fin) begin
			rx_data_r <= rx_word;
			rx_full_r <= 1'b1;
			rx_perr_r <= !spi && fcfg_r.parity_mode_field[1]
				&& (ucf_pkg::ucf_parity(rx_word, nb, fcfg_r.parity_mode_field[0]) != rx_par_r);
			rx_ferr_r <= !spi && !rx_val;
		end else if (rd_data) begin
			rx_full_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign rd_data = s_axi_arvalid && s_axi_arready && (s_axi_araddr == `UCF_OFF_DATA);

	always_comb begin
		stat = 32'h0;
		stat[`UCF_ST_RXFULL] = rx_full_r;
		stat[`UCF_ST_TXEMPTY] = !tx_buf_full_r;
		stat[`UCF_ST_TXDONE] = tx_done_r;
		stat[`UCF_ST_PERR] = rx_perr_r;
		stat[`UCF_ST_FERR] = rx_ferr_r;
		stat[`UCF_ST_BUSY] = (tx_state_r == ucf_pkg::UCF_TX_SHIFT);
		rd_ok = 1'b1;
		if (s_axi_araddr == `UCF_OFF_DATA) begin
			rd_val = {23'h0, rx_data_r};
		end else if (s_axi_araddr == `UCF_OFF_STATUS) begin
			rd_val = stat;
		end else if (s_axi_araddr == `UCF_OFF_CTRL_B) begin
			rd_val = {27'h0, ctrl_r};
		end else if (s_axi_araddr == `UCF_OFF_CTRL_C) begin
			rd_val = {22'h0, fcfg_r};
		end else if (s_axi_araddr == `UCF_OFF_BAUD) begin
			rd_val = {16'h0, baud_r};
		end else if (s_axi_araddr == `UCF_OFF_PIN) begin
			rd_val = {31'h0, invert_r};
		end else begin
			rd_val = 32'h0;
			rd_ok = 1'b0;
		end
		wr_ok = (aw_addr_r == `UCF_OFF_DATA) || (aw_addr_r == `UCF_OFF_STATUS)
			|| (aw_addr_r == `UCF_OFF_CTRL_B) || (aw_addr_r == `UCF_OFF_CTRL_C)
			|| (aw_addr_r == `UCF_OFF_BAUD) || (aw_addr_r == `UCF_OFF_PIN);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `UCF_RESP_OKAY;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0;
			w_strb_r <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `UCF_RESP_OKAY : `UCF_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `UCF_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_ok ? `UCF_RESP_OKAY : `UCF_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= ucf_pkg::ucf_ctrl_type'(`UCF_RST_CTRL_B);
			fcfg_r <= ucf_pkg::ucf_frame_cfg_type'(`UCF_RST_CTRL_C);
			baud_r <= `UCF_RST_BAUD;
			invert_r <= `UCF_RST_PIN;
		end else if (wr_go) begin
			if (aw_addr_r == `UCF_OFF_CTRL_B) begin
				ctrl_r <= ucf_pkg::ucf_ctrl_type'(5'(ucf_pkg::ucf_merge({27'h0, ctrl_r},
					w_data_r, w_strb_r)));
			end else if (aw_addr_r == `UCF_OFF_CTRL_C) begin
				fcfg_r <= ucf_pkg::ucf_frame_cfg_type'(10'(ucf_pkg::ucf_merge({22'h0, fcfg_r},
					w_data_r, w_strb_r)));
			end else if (aw_addr_r == `UCF_OFF_BAUD) begin
				baud_r <= 16'(ucf_pkg::ucf_merge({16'h0, baud_r}, w_data_r, w_strb_r));
			end else if (aw_addr_r == `UCF_OFF_PIN && w_strb_r[0]) begin
				invert_r <= w_data_r[0];
			end
		end
	end

	// Buffer accepts a write only while empty; a write to a full buffer is dropped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_buf_r <= 9'h000;
			tx_buf_full_r <= 1'b0;
		end else if (tx_load) begin
			tx_buf_full_r <= 1'b0;
		end else if (wr_go && aw_addr_r == `UCF_OFF_DATA && !tx_buf_full_r) begin
			tx_buf_r <= 9'(ucf_pkg::ucf_merge({23'h0, tx_buf_r}, w_data_r, w_strb_r));
			tx_buf_full_r <= 1'b1;
		end
	end

	// Completion set wins over a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_done_r <= 1'b0;
		end else if (tx_fin && !tx_load) begin
			tx_done_r <= 1'b1;
		end else if (wr_go && aw_addr_r == `UCF_OFF_STATUS && w_strb_r[0]
			&& w_data_r[`UCF_ST_TXDONE]) begin
			tx_done_r <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// file: ucf_chk.sv
// Bus handshake and frame timing checks for the serial unit
`timescale 1ns/1ns
`default_nettype none
module ucf_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic txd_out,
	input wire logic sync_clock_pin_oe
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer not held");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer not held");
	a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write answer late");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_aw_closed: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	a_ar_closed: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
		else $error("refused read returns data");
	a_start_min: assert property ($fell(txd_out) && !sync_clock_pin_oe |=> !txd_out [*7])
		else $error("low bit shorter than eight clocks");
endmodule
bind usart_clock_frame_gen ucf_chk i_ucf_chk (.*);
`default_nettype wire

// file: ucf_remote.sv
// Remote serial device: captures frames from the line and sends frames on request
`timescale 1ns/1ns
`default_nettype none
module ucf_remote #(
	parameter int BIT = 16
) (
	input wire logic aclk,
	input wire logic txd,
	output logic rxd
);
	logic [10:0] cap;
	int nfr;
	// Mid-bit sampling on the falling edge keeps clear of the sender's flops
	initial begin
		rxd = 1'b1;
		nfr = 0;
		cap = '1;
		forever begin
			@(negedge aclk);
			if (txd === 1'b0) begin
				repeat (BIT / 2) @(negedge aclk);
				for (int i = 0; i < 11; i++) begin
					repeat (BIT) @(negedge aclk);
					cap[i] = txd;
				end
				nfr++;
			end
		end
	end
	task automatic send(input logic [9:0] b);
		@(posedge aclk);
		rxd <= 1'b0;
		for (int i = 0; i < 10; i++) begin
			repeat (BIT) @(posedge aclk);
			rxd <= b[i];
		end
		repeat (BIT) @(posedge aclk);
		rxd <= 1'b1;
	endtask
endmodule
`default_nettype wire

// file: usart_clock_frame_gen_tb_top.sv
// Self-checking bench for the serial clock and frame generator
`timescale 1ns/1ns
`default_nettype none
`include "ucf_map.svh"
module usart_clock_frame_gen_tb_top;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, q;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic rxd_in, txd_out, txd_oe, sync_clock_pin_out, sync_clock_pin_oe;
	wire logic sync_clock_pin_in = sync_clock_pin_out;
	// Pulled-up line: it floats high while the transmitter lets go
	wire logic line = txd_oe ? txd_out : 1'b1;
	int bad_count, n_compared;
	usart_clock_frame_gen i_usart_clock_frame_gen (.*);
	ucf_remote i_ucf_remote (.aclk(aclk), .txd(line), .rxd(rxd_in));
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	task automatic print_verdict();
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic hang(input string nm);
		bad_count++;
		$display("CHECK FAILED %s expected done seen timeout", nm);
		print_verdict();
	endtask
	// Ready is raised only once the answer shows, so the slave must hold it
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, vl, tr;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_arvalid <= !w;
		for (int n = 0; n < 64; n++) begin
			@(negedge aclk);
			ta = w ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
			tw = s_axi_wvalid && s_axi_wready;
			vl = w ? s_axi_bvalid : s_axi_rvalid;
			tr = vl && (s_axi_bready || s_axi_rready);
			q = s_axi_rdata;
			rsp = w ? s_axi_bresp : s_axi_rresp;
			@(posedge aclk);
			if (ta) begin
				s_axi_awvalid <= 1'b0;
				s_axi_arvalid <= 1'b0;
			end
			if (tw) s_axi_wvalid <= 1'b0;
			if (tr) begin
				s_axi_bready <= 1'b0;
				s_axi_rready <= 1'b0;
				return;
			end
			s_axi_bready <= vl && w;
			s_axi_rready <= vl && !w;
		end
		hang("bus");
	endtask
	task automatic poll(input int bt, input logic v);
		for (int n = 0; n < 200; n++) begin
			bus(1'b0, `UCF_OFF_STATUS, 32'h0);
			if (q[bt] === v) return;
		end
		hang("status");
	endtask
	task automatic run(input logic v, output int c);
		for (c = 0; c < 400 && line === v; c++) @(negedge aclk);
		if (c == 400) hang("line");
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		bus(1'b0, `UCF_OFF_CTRL_C, 32'h0);
		chk("ctrl c reset", 32'h060, q);
		bus(1'b1, `UCF_OFF_BAUD, 32'hffffffff);
		bus(1'b0, `UCF_OFF_BAUD, 32'h0);
		chk("divisor width", 32'hffff, q);
		bus(1'b0, 8'h18, 32'h0);
		chk("unmapped resp", 32'h2, {30'h0, rsp});
		bus(1'b1, 8'h18, 32'h0);
		chk("unmapped write resp", 32'h2, {30'h0, rsp});
	endtask
	task automatic t_frames();
		logic [31:0] cfg[3] = '{32'h060, 32'h058, 32'h08c};
		logic [8:0] dat[3] = '{9'h0a5, 9'h035, 9'h1c3};
		int nb[3] = '{8, 7, 9};
		logic [10:0] e;
		logic p;
		int k;
		bus(1'b1, `UCF_OFF_BAUD, 32'h40);
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, `UCF_OFF_CTRL_C, cfg[i]);
			if (i == 0) bus(1'b1, `UCF_OFF_CTRL_B, 32'h3);
			k = i_ucf_remote.nfr;
			e = '1;
			p = cfg[i][2];
			for (int j = 0; j < nb[i]; j++) begin
				e[j] = dat[i][j];
				p = p ^ dat[i][j];
			end
			if (cfg[i][3]) e[nb[i]] = p;
			bus(1'b1, `UCF_OFF_DATA, {23'h0, dat[i]});
			for (int n = 0; n < 600 && i_ucf_remote.nfr == k; n++) @(posedge aclk);
			if (i_ucf_remote.nfr == k) hang("frame");
			chk("tx frame", {21'h0, e}, {21'h0, i_ucf_remote.cap});
			poll(5, 1'b0);
		end
	endtask
	task automatic t_rx();
		bus(1'b1, `UCF_OFF_CTRL_C, 32'h068);
		for (int b = 0; b < 2; b++) begin
			i_ucf_remote.send({1'b1, ^8'h5a ^ b[0], 8'h5a});
			poll(0, 1'b1);
			chk("parity flag", b, {31'h0, q[3]});
			bus(1'b0, `UCF_OFF_DATA, 32'h0);
			chk("rx char", 32'h5a, q);
		end
	endtask
	task automatic t_rate();
		logic [31:0] cb[6] = '{32'h3, 32'h7, 32'h3, 32'h13, 32'h13, 32'h13};
		logic [31:0] cc[6] = '{32'h060, 32'h060, 32'h060, 32'h061, 32'h263, 32'h363};
		logic [31:0] bd[6] = '{32'h40, 32'h40, 32'h80, 32'h80, 32'h80, 32'h80};
		int len[6] = '{16, 8, 32, 4, 4, 4};
		int w;
		bus(1'b1, `UCF_OFF_CTRL_B, 32'hb);
		@(negedge aclk);
		chk("open drain idle enable", 32'h0, {31'h0, txd_oe});
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, `UCF_OFF_BAUD, bd[i]);
			bus(1'b1, `UCF_OFF_CTRL_C, cc[i]);
			bus(1'b1, `UCF_OFF_CTRL_B, cb[i]);
			bus(1'b1, `UCF_OFF_DATA, 32'hee);
			run(1'b1, w);
			run(1'b0, w);
			run(1'b1, w);
			run(1'b0, w);
			chk("bit length", len[i], w);
			if (cb[i][4]) begin
				chk("clock pin drive", 32'h1, {31'h0, sync_clock_pin_oe});
				for (w = 0; w < 8 && sync_clock_pin_out; w++) @(negedge aclk);
				for (w = 0; w < 8 && !sync_clock_pin_out; w++) @(negedge aclk);
				for (w = 0; w < 8 && sync_clock_pin_out; w++) @(negedge aclk);
				chk("clock pin half period", 32'h2, w);
			end
			poll(5, 1'b0);
		end
	endtask
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_frames();
		t_rx();
		t_rate();
		print_verdict();
	end
endmodule
`default_nettype wire
